/* tb_top.sv */
// Self-checking bench of the bulk-in transmitter
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    import ubi_pkg::*;
    logic clk_i, rst_i, suspend_i, setup_i, host_stall_i, go, crc_ok, fail, busy, h_ack, h_to;
    logic fifo_valid = 1'b0;
    logic fifo_ready, tx_valid, tx_last, tx_tog, r_zlp, r_nak, r_stall, stalled;
    logic [3:0] ep;
    logic [7:0] fifo_data = 8'h00;
    logic [7:0] tx_data;
    ubi_token_s token;
    ubi_cfg_s cfg;
    logic [31:0] seed = 32'h52a54cc7;
    logic [9:0] expq[$];
    logic [7:0] src[$];
    logic [8:0] es[$];
    logic tog = 1'b0;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int tc[6][5] = '{'{0, 1, 0, 60, 0}, '{0, 1, 3, 600, 0}, '{0, 0, 0, 60, 0},
                     '{0, 0, 2, 131, 40}, '{1, 1, 0, 5, 7}, '{1, 1, 1, 500, 0}};
    localparam logic [9:0] EV_ZLP = 10'h200;
    localparam logic [9:0] EV_NAK = 10'h201;
    localparam logic [9:0] EV_STALL = 10'h202;

    ubi_bulk_in_transmitter dut (.clk_i(clk_i), .rst_i(rst_i), .token_i(token), .suspend_i(suspend_i),
        .setup_i(setup_i), .host_stall_i(host_stall_i), .host_ack_i(h_ack), .host_timeout_i(h_to),
        .cfg_i(cfg), .fifo_data_i(fifo_data), .fifo_valid_i(fifo_valid), .fifo_ready_o(fifo_ready),
        .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last), .tx_toggle_o(tx_tog),
        .resp_zlp_o(r_zlp), .resp_nak_o(r_nak), .resp_stall_o(r_stall), .ep_stalled_o(stalled));
    ubi_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ep_i(ep), .crc_ok_i(crc_ok),
        .fail_i(fail), .busy_o(busy), .token_o(token), .ack_o(h_ack), .timeout_o(h_to),
        .tx_valid_i(tx_valid), .tx_last_i(tx_last), .resp_zlp_i(r_zlp), .resp_nak_i(r_nak),
        .resp_stall_i(r_stall));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Receive FIFO source; offered data holds until taken, idle data changes every cycle
    always @(posedge clk_i) begin
        if (fifo_valid && fifo_ready) void'(src.pop_front());
        fifo_valid <= src.size() != 0;
        fifo_data <= (src.size() != 0) ? src[0] : ~fifo_data;
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            $display("unexpected at %0t: run too long", $time);
            report_and_stop();
        end
    end

    // Output watcher takes the oldest note for every result
    task automatic ev(input logic [9:0] got);
        logic [9:0] w;
        w = expq.size() != 0 ? expq.pop_front() : 10'h3ff;
        `CHK(got, w)
    endtask
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid) ev({1'b0, tx_last, tx_data});
        if (!rst_i && r_zlp) ev(EV_ZLP);
        if (!rst_i && r_nak) ev(EV_NAK);
        if (!rst_i && r_stall) ev(EV_STALL);
    end

    task automatic txn(input logic [3:0] e, input logic c, input logic f);
        int k;
        @(posedge clk_i);
        ep <= e;
        crc_ok <= c;
        fail <= f;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        for (k = 0; k < 1000 && (busy || k == 0); k++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask

    // Frame as status word, offset pads and data
    task automatic push_frame(input int len, input int off, input logic cl);
        logic [7:0] b;
        for (int i = 0; i < 4 + off + len; i++) begin
            b = (i == 0) ? len[7:0] : (i == 1) ? {2'h0, len[13:8]} : (i < 4 || i >= 4 + off) ? rnd() : 8'h00;
            if (i < 4 || i >= 4 + off) src.push_back(b);
            es.push_back({cl && i == 3 + off + len, b});
        end
    endtask

    // Cut the expected stream into packets; each is first timed out, then resent
    task automatic run(input int mps);
        logic [8:0] pk[$];
        logic cl;
        while (es.size() != 0) begin
            pk = {};
            cl = 1'b0;
            while (!cl && pk.size() < mps && es.size() != 0) begin
                cl = es[0][8];
                pk.push_back(es.pop_front());
            end
            repeat (600) @(posedge clk_i);
            for (int r = 0; r < 2; r++) begin
                foreach (pk[j]) expq.push_back({1'b0, j == pk.size() - 1, pk[j][7:0]});
                txn(EP_BULK_IN, 1'b1, r == 0);
            end
            tog = ~tog;
            `CHK(tx_tog, tog)
            if (cl && pk.size() == mps) begin
                expq.push_back(EV_ZLP);
                txn(EP_BULK_IN, 1'b1, 1'b0);
                tog = ~tog;
            end
        end
    endtask

    initial begin
        rst_i = 1'b1;
        {suspend_i, setup_i, host_stall_i, go, fail} = '0;
        crc_ok = 1'b1;
        ep = '0;
        cfg = '{1'b0, 1'b1, 5'h00};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        expq.push_back(EV_ZLP);
        txn(EP_BULK_IN, 1'b1, 1'b0);
        tog = ~tog;
        `CHK(tx_tog, tog)
        $display("test empty done");
        for (int e = 0; e < 4; e++) if (e != 1) txn(e[3:0], 1'b1, 1'b0);
        txn(EP_BULK_IN, 1'b0, 1'b0);
        suspend_i <= 1'b1;
        txn(EP_BULK_IN, 1'b1, 1'b0);
        suspend_i <= 1'b0;
        `CHK(tx_tog, tog)
        $display("test refused done");
        host_stall_i <= 1'b1;
        @(posedge clk_i);
        host_stall_i <= 1'b0;
        expq.push_back(EV_STALL);
        txn(EP_BULK_IN, 1'b1, 1'b0);
        `CHK(stalled, 1'b1)
        setup_i <= 1'b1;
        @(posedge clk_i);
        setup_i <= 1'b0;
        expq.push_back(EV_ZLP);
        txn(EP_BULK_IN, 1'b1, 1'b0);
        tog = ~tog;
        `CHK(stalled, 1'b0)
        $display("test stall done");
        for (int t = 0; t < 6; t++) begin
            cfg <= '{tc[t][0][0], tc[t][1][0], tc[t][2][4:0]};
            @(posedge clk_i);
            push_frame(tc[t][3], tc[t][2], !tc[t][0] || tc[t][4] == 0);
            if (tc[t][4] != 0) begin
                if (tc[t][0] != 0) repeat ((8 - (tc[t][2] + tc[t][3]) % 4) % 4) es.push_back(9'h000);
                push_frame(tc[t][4], tc[t][2], 1'b1);
            end
            run(tc[t][1] != 0 ? 512 : 64);
            $display("test packing %0d done", t);
        end
        cfg <= '{1'b0, 1'b1, 5'h00};
        push_frame(300, 0, 1'b1);
        expq.push_back(EV_NAK);
        txn(EP_BULK_IN, 1'b1, 1'b0);
        run(512);
        `CHK(expq.size() == 0, 1'b1)
        $display("test busy done");
        report_and_stop();
    end
endmodule // tb_top

/* ubi_bulk_in_transmitter.sv */
// Bulk-in transmitter with stall, retry and handshake control for endpoint 1
`timescale 1ns/1ps
module ubi_bulk_in_transmitter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Protocol engine side
    input wire ubi_pkg::ubi_token_s token_i,
    input wire logic suspend_i,
    input wire logic setup_i,
    input wire logic host_stall_i,
    input wire logic host_ack_i,
    input wire logic host_timeout_i,
    // Configuration
    input wire ubi_pkg::ubi_cfg_s cfg_i,
    // Receive FIFO
    input wire logic [7:0] fifo_data_i,
    input wire logic fifo_valid_i,
    output logic fifo_ready_o,
    // Packet out to transceiver
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    output logic tx_last_o,
    output logic tx_toggle_o,
    output logic resp_zlp_o,
    output logic resp_nak_o,
    output logic resp_stall_o,
    output logic ep_stalled_o
);
    import ubi_pkg::*;

    ubi_state_s s, n;
    logic we, re, wr, take, tok_hit;
    logic [AW-1:0] wa, ra;
    logic [7:0] wd;
    logic [CW-1:0] mps;

    function automatic logic [CW-1:0] max_pkt(input logic hs);
        return hs ? MPS_HS : MPS_FS;
    endfunction

    // Bulk-in token for endpoint 1 accepted only when awake and error free
    assign tok_hit = token_i.valid && token_i.crc_ok && !suspend_i && token_i.ep == EP_BULK_IN && token_i.ep < NUM_EP;

    always_comb begin
        n = s;
        wr = 1'b0;
        wd = 8'h00;
        take = 1'b0;
        re = 1'b0;
        ra = s.rd_ptr[AW-1:0];
        mps = max_pkt(cfg_i.hs);
        n.txv = 1'b0;
        n.txl = 1'b0;
        n.nak = 1'b0;
        n.zlp = 1'b0;
        n.stall = 1'b0;
        if (host_stall_i) begin
            n.stalled = 1'b1;
        end
        if (setup_i) begin
            n.stalled = 1'b0;
        end
        // Packet builder
        if (!s.pkt_rdy) begin
            case (s.bst)
                B_IDLE: begin
                    if (s.zlp_owed) begin
                        n.zlp_owed = 1'b0;
                        n.pkt_rdy = 1'b1;
                        n.pkt_len = '0;
                    end else if (fifo_valid_i) begin
                        n.bst = B_STAT;
                        n.stat_idx = STAT_LO;
                    end
                end
                B_STAT: begin
                    if (fifo_valid_i) begin
                        take = 1'b1;
                        wr = 1'b1;
                        wd = fifo_data_i;
                        n.stat_idx = s.stat_idx + 2'h1;
                        if (s.stat_idx == STAT_LO) begin
                            n.len_lo = fifo_data_i;
                        end
                        if (s.stat_idx == STAT_HI) begin
                            n.frm_rem = {fifo_data_i[LEN_HI_W-1:0], s.len_lo};
                        end
                        if (s.stat_idx == STAT_LAST) begin
                            n.pad_rem = cfg_i.offset;
                            n.bst = (cfg_i.offset != '0) ? B_PAD : B_DATA;
                        end
                    end
                end
                B_PAD: begin
                    wr = 1'b1;
                    n.pad_rem = s.pad_rem - OFF_W'(1);
                    if (s.pad_rem == OFF_W'(1)) begin
                        n.bst = B_DATA;
                    end
                end
                B_DATA: begin
                    if (s.frm_rem != '0) begin
                        if (fifo_valid_i) begin
                            take = 1'b1;
                            wr = 1'b1;
                            wd = fifo_data_i;
                            n.frm_rem = s.frm_rem - LEN_W'(1);
                        end
                    end else if (s.wr_cnt == '0) begin
                        n.zlp_owed = !cfg_i.multi_frame || !fifo_valid_i;
                        n.bst = B_IDLE;
                    end else if (!cfg_i.multi_frame || !fifo_valid_i) begin
                        n.pkt_rdy = 1'b1;
                        n.pkt_len = s.wr_cnt;
                        n.wr_cnt = '0;
                        n.bst = B_IDLE;
                    end else begin
                        n.bst = (s.wr_cnt[1:0] != 2'h0) ? B_ALIGN : B_IDLE;
                    end
                end
                B_ALIGN: begin
                    wr = 1'b1;
                    if (s.wr_cnt[1:0] == WORD_LAST) begin
                        n.bst = B_IDLE;
                    end
                end
                default: begin
                    n.bst = B_IDLE;
                end
            endcase
            if (wr) begin
                n.wr_cnt = s.wr_cnt + CW'(1);
                if (s.wr_cnt + CW'(1) == mps) begin
                    n.pkt_rdy = 1'b1;
                    n.pkt_len = mps;
                    n.wr_cnt = '0;
                end
            end
        end
        // Token answer and transmit
        case (s.tst)
            T_IDLE: begin
                if (tok_hit) begin
                    if (s.stalled) begin
                        n.stall = 1'b1;
                    end else if (s.pkt_rdy) begin
                        n.sent_real = 1'b1;
                        n.rd_ptr = '0;
                        if (s.pkt_len == '0) begin
                            n.zlp = 1'b1;
                            n.tst = T_WAIT;
                        end else begin
                            n.tst = T_SEND;
                        end
                    end else if (s.bst == B_IDLE && !fifo_valid_i && !s.zlp_owed) begin
                        n.zlp = 1'b1;
                        n.sent_real = 1'b0;
                        n.tst = T_WAIT;
                    end else begin
                        n.nak = 1'b1;
                    end
                end
            end
            T_SEND: begin
                re = 1'b1;
                n.txv = 1'b1;
                n.rd_ptr = s.rd_ptr + CW'(1);
                if (s.rd_ptr == s.pkt_len - CW'(1)) begin
                    n.txl = 1'b1;
                    n.tst = T_WAIT;
                end
            end
            T_WAIT: begin
                if (host_ack_i) begin
                    n.toggle = ~s.toggle;
                    if (s.sent_real) begin
                        n.pkt_rdy = 1'b0;
                    end
                    n.tst = T_IDLE;
                end else if (host_timeout_i) begin
                    n.tst = T_IDLE;
                end
            end
            default: begin
                n.tst = T_IDLE;
            end
        endcase
        we = wr && !s.pkt_rdy;
        wa = s.wr_cnt[AW-1:0];
    end

    // Single clock from the common clock block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{bst: B_IDLE, tst: T_IDLE, default: '0};
        end else begin
            s <= n;
        end
    end

    ubi_pkt_mem #(.W(8), .D(512), .A(AW)) u_mem (
        .clk_i(clk_i),
        .we_i(we),
        .waddr_i(wa),
        .wdata_i(wd),
        .re_i(re),
        .raddr_i(ra),
        .rdata_o(tx_data_o)
    );

    assign fifo_ready_o = take;
    assign tx_valid_o = s.txv;
    assign tx_last_o = s.txl;
    assign tx_toggle_o = s.toggle;
    assign resp_zlp_o = s.zlp;
    assign resp_nak_o = s.nak;
    assign resp_stall_o = s.stall;
    assign ep_stalled_o = s.stalled;

    // Checks
    a_fifo_hold_full: assert property (@(posedge clk_i) disable iff (rst_i)
        s.pkt_rdy |-> !fifo_ready_o) else $error("FIFO read while packet held");
    a_pkt_len_max: assert property (@(posedge clk_i) disable iff (rst_i)
        s.pkt_rdy |-> s.pkt_len <= max_pkt(cfg_i.hs)) else $error("Packet longer than max size");
    a_single_no_align: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.bst == B_DATA && s.frm_rem == '0 && !s.pkt_rdy && !cfg_i.multi_frame) |=> s.bst == B_IDLE)
        else $error("Single-frame packing went on past frame");
    a_align_only_multi: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.bst == B_DATA && s.frm_rem == '0 && !s.pkt_rdy && s.wr_cnt[1:0] != 2'h0
            && cfg_i.multi_frame && fifo_valid_i)
        |=> s.bst == B_ALIGN) else $error("Frame not padded to word");
    a_empty_zlp_ans: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.tst == T_IDLE && tok_hit && !s.stalled && !s.pkt_rdy && s.bst == B_IDLE && !fifo_valid_i && !s.zlp_owed)
        |=> resp_zlp_o ##1 !resp_zlp_o) else $error("Empty FIFO token not given ZLP");
    a_ack_flips_tog: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.tst == T_WAIT && host_ack_i) |=> tx_toggle_o != $past(tx_toggle_o)) else $error("Toggle kept after ACK");
    a_retry_same_tog: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.tst == T_WAIT && !host_ack_i && host_timeout_i) |=> $stable(tx_toggle_o) && s.pkt_rdy == $past(s.pkt_rdy))
        else $error("Retry lost packet or toggle");
    a_setup_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        setup_i |=> !ep_stalled_o) else $error("Setup did not clear stall");
    a_offset_pads: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.bst == B_STAT && s.stat_idx == STAT_LAST && fifo_valid_i && !s.pkt_rdy && cfg_i.offset != '0)
        |=> s.bst == B_PAD [*1] ##0 s.pad_rem == $past(cfg_i.offset)) else $error("Offset pad not inserted");
    a_zero_offset: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.bst == B_STAT && s.stat_idx == STAT_LAST && fifo_valid_i && !s.pkt_rdy && cfg_i.offset == '0)
        |=> s.bst == B_DATA) else $error("Pad bytes with zero offset");
    a_last_with_valid: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_last_o |-> tx_valid_o ##1 !tx_valid_o) else $error("Last byte not closing packet");

    c_full_packet: cover property (@(posedge clk_i) disable iff (rst_i) tx_last_o && s.pkt_len == MPS_HS);
    c_mef_align: cover property (@(posedge clk_i) disable iff (rst_i) s.bst == B_ALIGN);
    c_owed_zlp: cover property (@(posedge clk_i) disable iff (rst_i) s.zlp_owed ##[1:20] resp_zlp_o);
    c_retry: cover property (@(posedge clk_i) disable iff (rst_i) s.tst == T_WAIT && host_timeout_i);
endmodule // ubi_bulk_in_transmitter

/* ubi_host_model.sv */
// USB host model that issues bulk-in tokens and handshakes the answers
`timescale 1ns/1ps
module ubi_host_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic go_i,
    input wire logic [3:0] ep_i,
    input wire logic crc_ok_i,
    input wire logic fail_i,
    output logic busy_o,
    // Transmitter side
    output ubi_pkg::ubi_token_s token_o,
    output logic ack_o,
    output logic timeout_o,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    input wire logic resp_zlp_i,
    input wire logic resp_nak_i,
    input wire logic resp_stall_i
);
    import ubi_pkg::*;
    int i;
    logic hs;
    initial begin
        token_o = '0;
        ack_o = 1'b0;
        timeout_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i && !rst_i) begin
                busy_o <= 1'b1;
                token_o <= '{1'b1, ep_i, crc_ok_i};
                @(posedge clk_i);
                token_o <= '0;
                hs = 1'b0;
                // Wait for the answer; a refused token gets none
                for (i = 0; i < 700; i++) begin
                    @(posedge clk_i);
                    if (resp_nak_i || resp_stall_i) break;
                    if (resp_zlp_i || tx_last_i) begin
                        hs = 1'b1;
                        break;
                    end
                    if (i > 16 && !tx_valid_i) break;
                end
                // Handshake, or let it time out on request
                if (hs) begin
                    @(posedge clk_i);
                    ack_o <= !fail_i;
                    timeout_o <= fail_i;
                    @(posedge clk_i);
                    ack_o <= 1'b0;
                    timeout_o <= 1'b0;
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule // ubi_host_model

/* ubi_pkg_mem.sv */
// Constants, types and the packet memory of the bulk-in encapsulation block
// Overview of operation
// - Byte stream goes to the transceiver layer, which serialises, bit-stuffs and NRZI-codes it.
// - Protocol engine works in full-speed 1.1 or high-speed 2.0 mode.
// - Setup packet clears stall; suspend and reset handled without software.
// - Retry after errors keeps toggle; handshake chosen from buffer state.
// - One configuration, one interface, one alternate setting, four endpoints.
// - Endpoint 0 control, 1 bulk-in, 2 bulk-out, 3 interrupt.
// - Bulk-in transmitter packs receive FIFO frames into endpoint 1 packets.
// - Packing mode chosen by a configuration mode bit.
// - Multi-frame mode packs consecutive frames into one packet.
// - Single-frame mode holds at most one frame per packet.
// - Frames longer than 512 bytes span several packets.
// - Status word ahead of each frame gives length used to delimit frames.
// - Status word comes from the receive status word generator.
// - Nonzero data offset inserts that many pad bytes after status word.
// - Clocks come from the common clock block.
// - Burst ends with a short packet or a zero-length packet.
// - Bulk-in token with empty receive FIFO gets a zero-length packet.
// - Multi-frame: frames start word aligned; pad only if another frame follows.
// - Single-frame: zero-length packet after frame sized a packet multiple.
package ubi_pkg;
    localparam int AW = 9;
    localparam int CW = 10;
    localparam int LEN_W = 14;
    localparam int OFF_W = 5;
    localparam logic [9:0] MPS_HS = 10'h200;
    localparam logic [9:0] MPS_FS = 10'h040;
    localparam logic [3:0] EP_CTRL = 4'h0;
    localparam logic [3:0] EP_BULK_IN = 4'h1;
    localparam logic [3:0] EP_BULK_OUT = 4'h2;
    localparam logic [3:0] EP_INTR = 4'h3;
    localparam logic [3:0] NUM_EP = 4'h4;
    localparam logic [1:0] STAT_LO = 2'h0;
    localparam logic [1:0] STAT_HI = 2'h1;
    localparam logic [1:0] STAT_LAST = 2'h3;
    localparam logic [1:0] WORD_LAST = 2'h3;
    localparam int LEN_HI_W = 6;

    typedef enum logic [4:0] {
        B_IDLE = 5'h01,
        B_STAT = 5'h02,
        B_PAD = 5'h04,
        B_DATA = 5'h08,
        B_ALIGN = 5'h10
    } ubi_bst_e;

    typedef enum logic [2:0] {
        T_IDLE = 3'h1,
        T_SEND = 3'h2,
        T_WAIT = 3'h4
    } ubi_tst_e;

    typedef struct packed {
        logic valid;
        logic [3:0] ep;
        logic crc_ok;
    } ubi_token_s;

    typedef struct packed {
        logic multi_frame;
        logic hs;
        logic [OFF_W-1:0] offset;
    } ubi_cfg_s;

    typedef struct packed {
        ubi_bst_e bst;
        ubi_tst_e tst;
        logic [CW-1:0] wr_cnt;
        logic [LEN_W-1:0] frm_rem;
        logic [7:0] len_lo;
        logic [1:0] stat_idx;
        logic [OFF_W-1:0] pad_rem;
        logic pkt_rdy;
        logic [CW-1:0] pkt_len;
        logic zlp_owed;
        logic sent_real;
        logic toggle;
        logic stalled;
        logic [CW-1:0] rd_ptr;
        logic txv;
        logic txl;
        logic nak;
        logic zlp;
        logic stall;
    } ubi_state_s;
endpackage

`timescale 1ns/1ps
module ubi_pkt_mem #(
    parameter int W = 8,
    parameter int D = 512,
    parameter int A = 9
) (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [A-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    // Read port
    input wire logic re_i,
    input wire logic [A-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem_r [D];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule // ubi_pkt_mem
